// ===== rtl/external_bus_unit_defines.svh
// external bus unit: offsets, field positions and timing counts
// assumes inclusion by bare name from the design module
`ifndef EXTERNAL_BUS_UNIT_DEFINES_SVH
`define EXTERNAL_BUS_UNIT_DEFINES_SVH

// bus configuration word fields (16 bits)
`define BCFG_WAIT_LSB      0
`define BCFG_WAIT_W        4
`define BCFG_TRI_LSB       4
`define BCFG_TRI_W         2
`define BCFG_ALE_LSB       6
`define BCFG_ALE_W         2
`define BCFG_MODE_LSB      8
`define BCFG_MODE_W        2
`define BCFG_RWDLY_BIT     10
`define BCFG_CSEN_BIT      11
// window select word: base in upper bits, size code in low nibble
`define ASEL_SIZE_LSB      0
`define ASEL_SIZE_W        4
`define ASEL_BASE_LSB      4
`define ASEL_BASE_W        12
// system configuration bits
`define SYSCFG_PERIPH_BIT  2
`define SYSCFG_CSUNL_BIT   6
// address space codes
`define ASPACE_64K         2'h0
`define ASPACE_256K        2'h1
`define ASPACE_1M          2'h2
`define ASPACE_4M          2'h3
// on-chip peripheral region (bank 0x00E000-0x00EFFF)
`define PERIPH_BASE        22'h00E000
`define PERIPH_MASK        22'h3FF000
// least phase length in cycles
`define MIN_PHASE          4'h1

`endif

// ===== rtl/external_bus_unit_pkg.sv
// external bus unit: shared types
// assumes nothing of the defines header; only the design module includes it
package external_bus_unit_pkg;
	// bus mode field encoding; single chip has no external cycle
	typedef enum logic [1:0] {
		MODE_DEMUX8,
		MODE_MUX8,
		MODE_MUX16,
		MODE_DEMUX16
	} bus_mode_e;

	typedef logic [21:0] addr_t;
endpackage : external_bus_unit_pkg

// ===== rtl/external_bus_unit.sv
// external bus unit: runs external read/write cycles for the cpu side
// assumes a synchronous cpu request/ready handshake and synchronous pin inputs
`include "external_bus_unit_defines.svh"

// Behaviour
// - single-chip mode blocks external cycles; four mux/demux by 8/16 modes exist.
// - address width selectable as 16, 18, 20 or 22 bits.
// - demux drives address port; data on full port or low lane.
// - mux drives address on lower port, then data on same pins.
// - cycle time, tri-state time, latch strobe length, read/write delay programmable.
// - four windows, each an address select plus bus config pair.
// - window four beats three, window two beats one on overlap.
// - addresses outside all windows use the default bus config.
// - four active-low chip selects: three windows plus default region.
// - unlatch bit bypasses chip-select filter; selects follow address combinationally.
// - segment lines: six for 4M, four for 1M, two for 256K, none 64K.
// - with CAN on segment port, segment output limited to A19..A16.
// - strap low: latch config from lower port and read pin, boot external.
// - strap high: latch config from read and latch pins, boot internal.
// - each lower port pin has a direction bit; input means no drive.
// - 8-bit mux: low lane AD0-7, high lane A8-15; 16-bit both AD.
// - peripheral enable bit gates on-chip peripherals' address space only.
module external_bus_unit
	import external_bus_unit_pkg::*;
#(
	parameter int WINDOWS = 4
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        single_chip,
	input  wire logic [15:0] system_config,
	input  wire logic [1:0]  addr_space,
	input  wire logic        can_on_segment,
	input  wire logic [15:0] default_bus_config,
	input  wire logic [15:0] window_bus_config [WINDOWS],
	input  wire logic [15:0] window_address_select [WINDOWS],
	input  wire logic [15:0] port_dir,
	input  wire logic [15:0] port_out,
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic [21:0] req_addr,
	input  wire logic [15:0] req_wdata,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [15:0]      rsp_rdata,
	output logic             periph_sel,
	input  wire logic        ext_access_strap,
	input  wire logic [15:0] lower_bus_port_in,
	output logic [15:0]      lower_bus_port_out,
	output logic [15:0]      lower_bus_port_oe,
	output logic [15:0]      address_port,
	output logic [5:0]       segment_out,
	output logic [5:0]       segment_oe,
	output logic [3:0]       cs_n,
	output logic             ale,
	input  wire logic        rd_n_in,
	input  wire logic        ale_in,
	output logic             rd_n,
	output logic             wr_n,
	output logic             boot_external,
	output logic [15:0]      strap_config,
	output logic             strap_valid
);
	typedef enum {ST_IDLE, ST_ADDR, ST_TRI, ST_DLY, ST_DATA, ST_DONE} state_e;

	state_e      state_q, state_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [21:0] addr_q, addr_d;
	logic [15:0] wdata_q, wdata_d;
	logic [15:0] cfg_q, cfg_d;
	logic        write_q, write_d;
	logic [3:0]  cs_sel_q, cs_sel_d;
	logic [3:0]  cs_filt_q, cs_filt_d;
	logic [15:0] rdata_q, rdata_d;
	logic        rsp_q, rsp_d;
	logic        strap_done_q, strap_done_d;
	logic        boot_ext_q, boot_ext_d;
	logic [15:0] strap_cfg_q, strap_cfg_d;

	logic [WINDOWS-1:0] win_hit;
	logic [15:0]        sel_cfg;
	logic [3:0]         sel_cs;
	logic [21:0]        addr_mask;
	logic [21:0]        eff_addr;
	logic               periph_hit;
	bus_mode_e          mode;

	// address space width; upper bits above the selected space forced to zero
	always_comb begin
		case (addr_space)
			`ASPACE_64K:  addr_mask = 22'h00FFFF;
			`ASPACE_256K: addr_mask = 22'h03FFFF;
			`ASPACE_1M:   addr_mask = 22'h0FFFFF;
			default:      addr_mask = 22'h3FFFFF;
		endcase
	end
	assign eff_addr = req_addr & addr_mask;

	// window compare: size code n covers 4K << n bytes from the base
	generate
		for (genvar w = 0; w < WINDOWS; w++) begin : g_win
			logic [21:0] base;
			logic [21:0] wmask;
			logic [3:0]  sz;
			assign sz    = window_address_select[w][`ASEL_SIZE_LSB +: `ASEL_SIZE_W];
			assign base  = {window_address_select[w][`ASEL_BASE_LSB +: `ASEL_BASE_W],
				10'h000};
			assign wmask = 22'h3FFFFF << (5'h0C + {1'b0, sz});
			assign win_hit[w] = ((eff_addr & wmask) == (base & wmask))
				&& window_bus_config[w][`BCFG_CSEN_BIT];
		end
	endgenerate

	// window priority: four over three, two over one, pairs over default
	always_comb begin
		sel_cfg = default_bus_config;
		sel_cs  = 4'h1;
		if (WINDOWS > 3 && win_hit[3]) begin
			sel_cfg = window_bus_config[3];
			sel_cs  = 4'h0;
		end else if (WINDOWS > 2 && win_hit[2]) begin
			sel_cfg = window_bus_config[2];
			sel_cs  = 4'h8;
		end else if (win_hit[1]) begin
			sel_cfg = window_bus_config[1];
			sel_cs  = 4'h4;
		end else if (win_hit[0]) begin
			sel_cfg = window_bus_config[0];
			sel_cs  = 4'h2;
		end
	end

	// on-chip peripherals claim their region only while enabled
	assign periph_hit = system_config[`SYSCFG_PERIPH_BIT]
		&& ((req_addr & `PERIPH_MASK) == `PERIPH_BASE);
	assign periph_sel = periph_hit && req_valid;

	assign mode = bus_mode_e'(cfg_q[`BCFG_MODE_LSB +: `BCFG_MODE_W]);

	// bus cycle sequencer; a zero length field still costs one cycle
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		addr_d    = addr_q;
		wdata_d   = wdata_q;
		cfg_d     = cfg_q;
		write_d   = write_q;
		cs_sel_d  = cs_sel_q;
		rdata_d   = rdata_q;
		rsp_d     = 1'b0;
		req_ready = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// single chip or peripheral hit: no external cycle
				req_ready = strap_done_q && !single_chip && !periph_hit;
				if (req_valid && req_ready) begin
					addr_d   = eff_addr;
					wdata_d  = req_wdata;
					write_d  = req_write;
					cfg_d    = sel_cfg;
					cs_sel_d = sel_cs;
					cnt_d    = `MIN_PHASE
						+ {2'h0, sel_cfg[`BCFG_ALE_LSB +: `BCFG_ALE_W]};
					state_d  = ST_ADDR;
				end
			end
			ST_ADDR: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					cnt_d   = `MIN_PHASE + {2'h0, cfg_q[`BCFG_TRI_LSB +: `BCFG_TRI_W]};
					state_d = ST_TRI;
				end
			end
			ST_TRI: begin
				// tri-state gap lets the previous driver release the port
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					cnt_d   = `MIN_PHASE;
					state_d = cfg_q[`BCFG_RWDLY_BIT] ? ST_DLY : ST_DATA;
					if (!cfg_q[`BCFG_RWDLY_BIT])
						cnt_d = `MIN_PHASE + cfg_q[`BCFG_WAIT_LSB +: `BCFG_WAIT_W];
				end
			end
			ST_DLY: begin
				cnt_d   = `MIN_PHASE + cfg_q[`BCFG_WAIT_LSB +: `BCFG_WAIT_W];
				state_d = ST_DATA;
			end
			ST_DATA: begin
				cnt_d = cnt_q - 4'h1;
				if (cnt_q == 4'h1) begin
					// 8-bit modes return only the low lane
					if (mode == MODE_DEMUX8 || mode == MODE_MUX8)
						rdata_d = {8'h00, lower_bus_port_in[7:0]};
					else
						rdata_d = lower_bus_port_in;
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				rsp_d   = 1'b1;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// chip-select filter holds the decoded select across the whole cycle
	always_comb begin
		cs_filt_d = 4'h0;
		if (state_d != ST_IDLE && state_d != ST_DONE)
			cs_filt_d = cs_sel_d;
	end

	// reset-time strap capture, once after release
	always_comb begin
		strap_done_d = 1'b1;
		boot_ext_d   = strap_done_q ? boot_ext_q : !ext_access_strap;
		strap_cfg_d  = strap_cfg_q;
		if (!strap_done_q) begin
			if (!ext_access_strap)
				strap_cfg_d = {lower_bus_port_in[15:1], rd_n_in};
			else
				strap_cfg_d = {14'h0000, ale_in, rd_n_in};
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q      <= ST_IDLE;
			cnt_q        <= 4'h0;
			addr_q       <= 22'h000000;
			wdata_q      <= 16'h0000;
			cfg_q        <= 16'h0000;
			write_q      <= 1'b0;
			cs_sel_q     <= 4'h0;
			cs_filt_q    <= 4'h0;
			rdata_q      <= 16'h0000;
			rsp_q        <= 1'b0;
			strap_done_q <= 1'b0;
			boot_ext_q   <= 1'b0;
			strap_cfg_q  <= 16'h0000;
		end else begin
			state_q      <= state_d;
			cnt_q        <= cnt_d;
			addr_q       <= addr_d;
			wdata_q      <= wdata_d;
			cfg_q        <= cfg_d;
			write_q      <= write_d;
			cs_sel_q     <= cs_sel_d;
			cs_filt_q    <= cs_filt_d;
			rdata_q      <= rdata_d;
			rsp_q        <= rsp_d;
			strap_done_q <= strap_done_d;
			boot_ext_q   <= boot_ext_d;
			strap_cfg_q  <= strap_cfg_d;
		end
	end

	// chip selects: latched by default, raw decode when unlatched mode is set
	always_comb begin
		if (system_config[`SYSCFG_CSUNL_BIT])
			cs_n = ~(req_valid && !single_chip && !periph_hit ? sel_cs : 4'h0);
		else
			cs_n = ~cs_filt_q;
	end

	// pin drive: address phase on shared port in mux modes, data after
	always_comb begin
		lower_bus_port_out = port_out;
		lower_bus_port_oe  = port_dir;
		address_port       = addr_q[15:0];
		ale                = 1'b0;
		rd_n               = 1'b1;
		wr_n               = 1'b1;
		if (state_q != ST_IDLE && state_q != ST_DONE) begin
			lower_bus_port_oe = 16'h0000;
			if (state_q == ST_ADDR && (mode == MODE_MUX8 || mode == MODE_MUX16)) begin
				ale                = 1'b1;
				lower_bus_port_out = addr_q[15:0];
				lower_bus_port_oe  = 16'hFFFF;
			end
			if (mode == MODE_MUX8) begin
				lower_bus_port_out[15:8] = addr_q[15:8];
				lower_bus_port_oe[15:8]  = 8'hFF;
			end
			if (state_q == ST_DATA) begin
				rd_n = write_q;
				wr_n = !write_q;
				if (write_q) begin
					lower_bus_port_out[7:0] = wdata_q[7:0];
					lower_bus_port_oe[7:0]  = 8'hFF;
					if (mode == MODE_MUX16 || mode == MODE_DEMUX16) begin
						lower_bus_port_out[15:8] = wdata_q[15:8];
						lower_bus_port_oe[15:8]  = 8'hFF;
					end
				end
			end
		end
	end

	// segment lines by address space; CAN takes the top two
	always_comb begin
		segment_out = addr_q[21:16];
		case (addr_space)
			`ASPACE_64K:  segment_oe = 6'h00;
			`ASPACE_256K: segment_oe = 6'h03;
			`ASPACE_1M:   segment_oe = 6'h0F;
			default:      segment_oe = 6'h3F;
		endcase
		if (can_on_segment)
			segment_oe = segment_oe & 6'h0F;
	end

	assign rsp_valid     = rsp_q;
	assign rsp_rdata     = rdata_q;
	assign boot_external = boot_ext_q;
	assign strap_config  = strap_cfg_q;
	assign strap_valid   = strap_done_q;
endmodule : external_bus_unit

// ===== tb/ext_memory_model.sv
// external memory model on the far side of the lower bus port
// assumes the unit's strobes are active low and ale marks a valid address
module ext_memory_model (
	input  wire logic        core_clk,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [15:0] address_port,
	input  wire logic [15:0] lower_bus_port_out,
	output logic [15:0]      lower_bus_port_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [256];
	logic [15:0] lat_q = 16'h0000;
	logic [15:0] last_q = 16'hA5C3;  // known level, the board holds straps valid
	logic        mux_q = 1'b0;
	logic        strb_q = 1'b0;
	logic [7:0]  idx;
	// mux cycles index by the latched address, demux cycles by the address port
	assign idx = mux_q ? lat_q[7:0] : address_port[7:0];
	// address latch, write capture and end-of-strobe bookkeeping
	always @(posedge core_clk) begin
		strb_q <= !rd_n || !wr_n;
		if (ale) begin
			lat_q <= lower_bus_port_out;  // latch holds the address seen under ale
			mux_q <= 1'b1;
		end else if (strb_q && rd_n && wr_n) begin
			mux_q <= 1'b0;
		end
		if (!wr_n) begin
			mem[idx] <= lower_bus_port_out;
		end
		if (!rd_n) begin
			last_q <= mem[idx];
		end
	end
	// released bus shows the inverse, so a stale sample never matches
	assign lower_bus_port_in = !rd_n ? mem[idx] : ~last_q;
endmodule : ext_memory_model

// ===== tb/external_bus_unit_monitor.sv
// port checker for the external bus unit
// assumes binding to the design module; one clock, async active-low reset
module external_bus_unit_monitor
	import external_bus_unit_pkg::*;
#(
	parameter int WINDOWS = 4
) (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        single_chip,
	input wire logic [15:0] system_config,
	input wire logic [1:0]  addr_space,
	input wire logic        can_on_segment,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic        rsp_valid,
	input wire logic        periph_sel,
	input wire logic [15:0] lower_bus_port_oe,
	input wire logic [5:0]  segment_oe,
	input wire logic [3:0]  cs_n,
	input wire logic        ale,
	input wire logic        rd_n,
	input wire logic        strap_valid,
	input wire logic        boot_external
);
	logic [5:0] seg_max;
	// segment lines allowed by the space size; CAN takes the top two
	assign seg_max = ~(6'h3F << {addr_space, 1'b0}) & (can_on_segment ? 6'h0F : 6'h3F);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence s_take; req_valid && req_ready; endsequence
	sequence s_answer; ##[4:28] rsp_valid; endsequence
	property p_single; single_chip |-> !req_ready; endproperty
	a_single: assert property (p_single) else $error("ready in single chip");
	property p_periph; periph_sel |-> !req_ready && system_config[2]; endproperty
	a_periph: assert property (p_periph) else $error("peripheral hit taken");
	property p_cs; $onehot0(~cs_n); endproperty
	a_cs: assert property (p_cs) else $error("two selects low");
	property p_ale; !rd_n |-> !ale; endproperty
	a_ale: assert property (p_ale) else $error("latch strobe in data");
	property p_rd_oe; !rd_n |-> lower_bus_port_oe[7:0] == 8'h00; endproperty
	a_rd_oe: assert property (p_rd_oe) else $error("port driven on read");
	property p_seg; (segment_oe & ~seg_max) == 6'h00; endproperty
	a_seg: assert property (p_seg) else $error("too many segment lines");
	property p_answer; s_take |-> s_answer; endproperty
	a_answer: assert property (p_answer) else $error("no answer in time");
	property p_busy; s_take |=> !req_ready [*3]; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_strap; strap_valid |=> strap_valid && $stable(boot_external); endproperty
	a_strap: assert property (p_strap) else $error("strap changed");
	property p_pulse; rsp_valid |=> !rsp_valid; endproperty
	a_pulse: assert property (p_pulse) else $error("response too long");
endmodule : external_bus_unit_monitor

// ===== tb/tb_external_bus_unit.sv
// testbench for the external bus unit with an external memory model
// assumes the unit answers each request once and refuses while busy
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) err(n, e, a); end
module tb_external_bus_unit
	import external_bus_unit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {addr_t a; logic [15:0] d; logic [15:0] c; logic [3:0] cs;} row_s;
	logic        core_clk, reset_n, single_chip, can_on_segment, req_valid, req_write;
	logic        ext_access_strap, rd_n_in, ale_in, req_ready, rsp_valid, periph_sel;
	logic        ale, rd_n, wr_n, boot_external, strap_valid;
	logic [15:0] system_config, default_bus_config, port_dir, port_out, req_wdata;
	logic [15:0] window_bus_config [4];
	logic [15:0] window_address_select [4];
	logic [15:0] rsp_rdata, lower_bus_port_in, lower_bus_port_out, lower_bus_port_oe;
	logic [15:0] address_port, strap_config;
	logic [5:0]  segment_out, segment_oe;
	logic [3:0]  cs_n;
	logic [1:0]  addr_space;
	addr_t       req_addr;
	int          fails, total_checks;
	// one row per winning window: default, w1, w2 over w1, w3, w4 over w3
	row_s rows [5] = '{'{22'h000100, 16'h1234, 16'h0B01, 4'hE},
		'{22'h011024, 16'h5678, 16'h0E13, 4'hD}, '{22'h010004, 16'h9ABC, 16'h0940, 4'hB},
		'{22'h02101C, 16'hDEF0, 16'h0825, 4'h7}, '{22'h020008, 16'h2468, 16'h0A87, 4'hF}};
	// 64K space folds this window address down into the default region
	row_s        fold_row = '{22'h02101C, 16'h7E81, 16'h0B01, 4'hE};
	// segment lines per space code: none, two, four, six
	logic [5:0]  seg_exp [4] = '{6'h00, 6'h03, 6'h0F, 6'h3F};
	external_bus_unit i_external_bus_unit (.*);
	ext_memory_model i_ext_memory_model (.*);
	// free-running clock
	always #50 core_clk = ~core_clk;
	task automatic err(input string n, input logic [31:0] e, input logic [31:0] a);
		fails++;
		$display("Error %s: expected %h, seen %h", n, e, a);
	endtask : err
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	// bounded wait for the answer pulse; a timeout ends the run as a failure
	task automatic wait_rsp();
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 40);
		if (rsp_valid !== 1'b1) begin
			err("rsp timeout", 1, rsp_valid);
			end_sim();
		end
	endtask : wait_rsp
	// one cycle, held until taken; latency counted from the take edge
	task automatic xfer(input row_s r, input logic w);
		int   n;
		int   nr;
		int   nw;
		logic mux;
		mux = r.c[9] ^ r.c[8];
		nr = 0;
		nw = 0;
		req_write <= w;
		req_addr <= r.a;
		req_wdata <= r.d;
		req_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		// a request never taken is a failure, not a hang
		if (req_ready !== 1'b1) begin
			err("ready timeout", 1, req_ready);
			end_sim();
		end
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (n == 1) begin
				`CHK("cs_n", r.cs, cs_n)
				if (mux) begin
					`CHK("ale", 1'b1, ale)
					`CHK("mux addr", r.a[15:0], lower_bus_port_out)
					`CHK("mux oe", 16'hFFFF, lower_bus_port_oe)
				end else begin
					`CHK("demux addr", r.a[15:0], address_port)
					`CHK("demux ale", 1'b0, ale)
					`CHK("demux oe", 16'h0000, lower_bus_port_oe)
				end
			end
			// strobe cycles counted over the whole transfer
			nr += (rd_n === 1'b0);
			nw += (wr_n === 1'b0);
		end while (rsp_valid !== 1'b1 && n < 40);
		if (rsp_valid !== 1'b1) begin
			err("rsp timeout", 1, rsp_valid);
			end_sim();
		end
		`CHK("latency", 32'(4 + r.c[7:6] + r.c[5:4] + r.c[10] + r.c[3:0]), n - 1)
		`CHK("wr_n low", w ? 1 + r.c[3:0] : 0, nw)
		`CHK("rd_n low", w ? 0 : 1 + r.c[3:0], nr)
		if (!w) begin
			`CHK("rdata", r.c[9:8] < 2'h2 ? {8'h00, r.d[7:0]} : r.d, rsp_rdata)
		end
	endtask : xfer
	// reset, table of windows and modes, then refusals, straps and segments
	initial begin
		core_clk = 1'b0;
		reset_n = 1'b0;
		{single_chip, can_on_segment, req_valid, req_write, ale_in} = '0;
		{ext_access_strap, rd_n_in} = 2'b11;
		{system_config, req_wdata, port_out, req_addr} = '0;
		port_dir = 16'h00F0;
		addr_space = 2'h3;
		default_bus_config = 16'h0B01;
		window_address_select = '{16'h0401, 16'h0400, 16'h0801, 16'h0800};
		window_bus_config = '{16'h0E13, 16'h0940, 16'h0825, 16'h0A87};
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		`CHK("strap early", 1'b0, strap_valid)
		@(posedge core_clk);
		`CHK("strap valid", 1'b1, strap_valid)
		`CHK("boot ext", 1'b0, boot_external)
		`CHK("strap cfg", 16'h0001, strap_config)
		`CHK("idle oe", port_dir, lower_bus_port_oe)
		foreach (rows[i]) begin
			xfer(rows[i], 1'b1);
			xfer(rows[i], 1'b0);
		end
		// refused request: single chip keeps every select off, even unlatched
		single_chip <= 1'b1;
		system_config <= 16'h0040;
		req_addr <= 22'h02101C;
		req_valid <= 1'b1;
		repeat (2) @(posedge core_clk);
		`CHK("ready single", 1'b0, req_ready)
		`CHK("cs single", 4'hF, cs_n)
		// unlatched selects follow the raw decode before the take, then drop with it
		single_chip <= 1'b0;
		@(posedge core_clk);
		`CHK("cs unlatched", 4'h7, cs_n)
		`CHK("ready taken", 1'b1, req_ready)
		req_valid <= 1'b0;
		@(posedge core_clk);
		`CHK("cs bypass", 4'hF, cs_n)
		// a peripheral hit waits behind the running cycle and is never taken
		system_config <= 16'h0004;
		req_addr <= 22'h00E010;
		req_valid <= 1'b1;
		wait_rsp();
		@(posedge core_clk);
		`CHK("periph sel", 1'b1, periph_sel)
		`CHK("ready periph", 1'b0, req_ready)
		`CHK("seg addr", 6'h02, segment_out)
		req_valid <= 1'b0;
		system_config <= 16'h0000;
		for (int i = 0; i < 8; i++) begin
			addr_space <= i[1:0];
			can_on_segment <= i[2];
			@(posedge core_clk);
			`CHK("seg oe", seg_exp[i % 4] & (i[2] ? 6'h0F : 6'h3F), segment_oe)
		end
		// 64K space masks the upper bits before the window compare
		addr_space <= 2'h0;
		can_on_segment <= 1'b0;
		xfer(fold_row, 1'b1);
		xfer(fold_row, 1'b0);
		`CHK("seg folded", 6'h00, segment_out)
		// second reset with the strap low boots from outside
		reset_n <= 1'b0;
		ext_access_strap <= 1'b0;
		repeat (2) @(posedge core_clk);
		`CHK("reset cs", 4'hF, cs_n)
		`CHK("reset strap", 1'b0, strap_valid)
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		`CHK("boot ext", 1'b1, boot_external)
		`CHK("strap rd", rd_n_in, strap_config[0])
		end_sim();
	end
endmodule : tb_external_bus_unit
bind external_bus_unit external_bus_unit_monitor #(.WINDOWS(WINDOWS)) i_external_bus_unit_monitor (.*);
